/* File: src/bae_regs.svh */
/*
 * register offsets, field positions, bus answers and cycle counts of the
 * branch and data-processing execute block. assumes an 8-bit byte address.
 */
`ifndef BAE_REGS_SVH
`define BAE_REGS_SVH

// register byte offsets
`define BAE_OFF_INSTR     8'h00
`define BAE_OFF_PC        8'h04
`define BAE_OFF_CURRENT_STATUS_REGISTER      8'h08
`define BAE_OFF_SAVED_STATUS_REGISTER      8'h0c
`define BAE_OFF_STAT      8'h10
`define BAE_GPR_SEL       2'b01
// status flag field of the status registers and nzcv nibble positions
`define BAE_CURRENT_STATUS_REGISTER_NZCV     31:28
`define BAE_FL_N          3
`define BAE_FL_Z          2
`define BAE_FL_C          1
`define BAE_FL_V          0
// status word bits
`define BAE_ST_BUSY       0
`define BAE_ST_PASS       1
`define BAE_ST_UNSUP      2
`define BAE_ST_CYC        8
// register indices and address arithmetic
`define BAE_LINK_IDX      4'he
`define BAE_PC_IDX        4'hf
`define BAE_INSN_BYTES    32'h0000_0004
`define BAE_PC_AHEAD      32'h0000_0008
`define BAE_PC_AHEAD_RS   32'h0000_000c
`define BAE_LINK_MASK     32'hffff_fffc
// cycle counts per instruction class
`define BAE_CYC_SKIP      4'h1
`define BAE_CYC_DP        4'h1
`define BAE_CYC_RS        4'h2
`define BAE_CYC_PCW       4'h2
`define BAE_CYC_BRANCH    4'h3
// bus answers
`define BAE_RESP_OKAY     2'b00
`define BAE_RESP_SLVERR   2'b10

`endif

/* File: src/bae_pkg.sv */
/*
 * types of the execute block: states, opcodes, shift kinds, core state.
 * assumes nothing of its surroundings.
 */
package bae_pkg;

	// sequencer states, gray along idle -> exec -> hold
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_exec = 2'b01,
		st_hold = 2'b11
	} bae_state_t;

	// data-processing opcodes
	typedef enum logic [3:0] {
		conjunction_op, exclusive_or_op, difference_op, reverse_difference,
		sum_op, sum_with_carry, difference_with_borrow, reverse_difference_borrow,
		bit_test_op, equality_test_op, compare_op, compare_negated_op,
		inclusive_or_op, copy_op, bit_clear_op, copy_inverted_op
	} bae_op_t;

	// shifter kinds
	typedef enum logic [1:0] {
		shift_left_logical, shift_right_logical, shift_right_arith, rotate_right
	} bae_shift_t;

	// whole state of the core module
	typedef struct packed {
		logic [15:0][31:0] gpr;
		logic [31:0]       pc;
		logic [31:0]       current_status_register;
		logic [31:0]       saved_status_register;
		logic [31:0]       instr;
		bae_state_t        state;
		logic [3:0]        cnt;
		logic              last_pass;
		logic              last_unsup;
		logic [3:0]        last_cyc;
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} bae_core_t;

endpackage

/* File: src/bae_dp_if.sv */
/*
 * bundle between the sequencer and the shifter/alu datapath.
 * assumes both ends sit on the same clock; the datapath is combinational.
 */
interface bae_dp_if;
	logic [31:0] instr;      // instruction under execution
	logic [31:0] rn_v;       // first operand value
	logic [31:0] rm_v;       // register to be shifted
	logic [31:0] rs_v;       // register holding a shift amount
	logic [3:0]  flags_in;   // current nzcv
	logic [31:0] res;        // alu result
	logic [3:0]  flags_out;  // candidate nzcv
	logic        wr_rd;      // result goes to a destination

	modport core (output instr, rn_v, rm_v, rs_v, flags_in, input res, flags_out, wr_rd);
	modport unit (input instr, rn_v, rm_v, rs_v, flags_in, output res, flags_out, wr_rd);
endinterface

/* File: src/bae_alu.sv */
/*
 * barrel shifter, immediate rotator and sixteen-opcode alu with flag logic.
 * purely combinational; assumes operands stay steady while it is read.
 */
`include "bae_regs.svh"

module bae_alu (
	bae_dp_if.unit dp   // operands in, result and flags out
);
	import bae_pkg::*;

	logic [31:0] ins;    // instruction word
	logic [31:0] rm;     // value to shift
	logic [31:0] op1;    // first operand
	logic [31:0] op2;    // second operand
	logic        c_old;  // carry before the instruction
	logic        v_old;  // overflow before the instruction
	logic        sh_c;   // shifter carry out
	logic        zcode;  // shift amount field reads zero
	logic [7:0]  amt;    // effective shift amount
	logic [63:0] wide;   // shift scratch
	logic [31:0] x;      // adder left input
	logic [31:0] y;      // adder right input
	logic        cin;    // adder carry in
	logic        arith;  // arithmetic class
	logic [31:0] res;    // result
	logic [32:0] sum;    // adder output with carry

	assign ins   = dp.instr;
	assign rm    = dp.rm_v;
	assign op1   = dp.rn_v;
	assign c_old = dp.flags_in[`BAE_FL_C];
	assign v_old = dp.flags_in[`BAE_FL_V];
	assign zcode = !ins[4] && (ins[11:7] == 5'h0);

	// second operand: rotated immediate or shifted register
	always_comb begin
		wide = 64'h0;
		amt  = 8'h0;
		op2  = rm;
		sh_c = c_old;
		if (ins[25]) begin
			// zero-extend and rotate right by twice the field
			wide = {2{24'h0, ins[7:0]}} >> {ins[11:8], 1'b0};
			op2  = wide[31:0];
			if (ins[11:8] != 4'h0) begin
				sh_c = op2[31];
			end
		end else begin
			// amount from the field or from a register byte
			amt = ins[4] ? dp.rs_v[7:0] : {3'h0, ins[11:7]};
			// zero field encodes 32 for right shifts
			if (zcode && ins[6:5] != 2'b00) begin
				amt = 8'h20;
			end
			unique case (bae_shift_t'(ins[6:5]))
				shift_left_logical: begin
					wide = {32'h0, rm} << amt;
					if (amt != 8'h0) begin
						op2  = wide[31:0];
						sh_c = wide[32];
					end
				end
				shift_right_logical: begin
					wide = {rm, 32'h0} >> amt;
					if (amt != 8'h0) begin
						op2  = wide[63:32];
						sh_c = wide[31];
					end
				end
				shift_right_arith: begin
					wide = $signed({rm, 32'h0}) >>> ((amt > 8'h20) ? 8'h20 : amt);
					if (amt != 8'h0) begin
						op2  = wide[63:32];
						sh_c = wide[31];
					end
				end
				rotate_right: begin
					if (zcode) begin
						// rotate through carry by one
						op2  = {c_old, rm[31:1]};
						sh_c = rm[0];
					end else if (amt != 8'h0) begin
						wide = {rm, rm} >> amt[4:0];
						op2  = wide[31:0];
						sh_c = op2[31];
					end
				end
			endcase
		end
	end

	// alu: all arithmetic through one adder
	always_comb begin
		x     = op1;
		y     = ~op2;
		cin   = 1'b1;
		arith = 1'b1;
		res   = 32'h0;
		unique case (bae_op_t'(ins[24:21]))
			conjunction_op, bit_test_op: begin
				arith = 1'b0;
				res   = op1 & op2;
			end
			exclusive_or_op, equality_test_op: begin
				arith = 1'b0;
				res   = op1 ^ op2;
			end
			difference_op, compare_op: begin
				cin = 1'b1;
			end
			reverse_difference: begin
				x = op2;
				y = ~op1;
			end
			sum_op, compare_negated_op: begin
				y   = op2;
				cin = 1'b0;
			end
			sum_with_carry: begin
				y   = op2;
				cin = c_old;
			end
			difference_with_borrow: begin
				cin = c_old;
			end
			reverse_difference_borrow: begin
				x   = op2;
				y   = ~op1;
				cin = c_old;
			end
			inclusive_or_op: begin
				arith = 1'b0;
				res   = op1 | op2;
			end
			copy_op: begin
				arith = 1'b0;
				res   = op2;
			end
			bit_clear_op: begin
				arith = 1'b0;
				res   = op1 & ~op2;
			end
			copy_inverted_op: begin
				arith = 1'b0;
				res   = ~op2;
			end
		endcase
		sum = {1'b0, x} + {1'b0, y} + {32'h0, cin};
		if (arith) begin
			res = sum[31:0];
		end
	end

	// nzcv candidates, in n z c v order
	assign dp.flags_out = arith
		? {res[31], res == 32'h0, sum[32], (x[31] == y[31]) && (sum[31] != x[31])}
		: {res[31], res == 32'h0, sh_c, v_old};
	assign dp.res   = res;
	assign dp.wr_rd = (ins[24:23] != 2'b10);

endmodule // bae_alu

/* File: src/bae_core.sv */
/*
 * execute block: axi4-lite register slave, register file, status
 * registers, condition check, branch unit and sequencing of the alu.
 * assumes an axi4-lite master on the same clock and one outstanding
 * read and one outstanding write at most.
 */
// The AXI4-Lite register port and the address map were decided locally.
`include "bae_regs.svh"

// Operation
// - execute only when condition field passes
// - pattern 101 is branch; bit 24 links
// - target adds offset shifted two, sign-extended
// - branch base is own address plus eight
// - link gets next address, low bits cleared
// - plain branch leaves link register alone
// - branches take three cycles
// - immediate bit picks rotated constant or shift
// - flags change only with set-flags bit
// - test and compare never write destination
// - opcodes zero to seven as listed
// - opcodes eight to fifteen as listed
// - logical flags: keep v, carry from shifter
// - arithmetic flags: signed overflow, adder carry
// - shift amount from field or register byte
// - field amount is five bits, zero to 31
// - left shift fills zeros, carries last bit
// - code 1110 always; 1111 reserved
// - immediate rotated right by twice field
// - pc destination with flags restores saved status
// - right shift field zero means 32
module bae_core (
	// clock and reset
	input  wire logic          CLOCK_IN,
	input  wire logic          RSTN_IN,
	// write address channel
	input  wire logic [7:0]    S_AXI_AWADDR_IN,
	input  wire logic          S_AXI_AWVALID_IN,
	output logic               S_AXI_AWREADY_OUT,
	// write data channel
	input  wire logic [31:0]   S_AXI_WDATA_IN,
	input  wire logic [3:0]    S_AXI_WSTRB_IN,
	input  wire logic          S_AXI_WVALID_IN,
	output logic               S_AXI_WREADY_OUT,
	// write response channel
	output logic [1:0]         S_AXI_BRESP_OUT,
	output logic               S_AXI_BVALID_OUT,
	input  wire logic          S_AXI_BREADY_IN,
	// read address channel
	input  wire logic [7:0]    S_AXI_ARADDR_IN,
	input  wire logic          S_AXI_ARVALID_IN,
	output logic               S_AXI_ARREADY_OUT,
	// read data channel
	output logic [31:0]        S_AXI_RDATA_OUT,
	output logic [1:0]         S_AXI_RRESP_OUT,
	output logic               S_AXI_RVALID_OUT,
	input  wire logic          S_AXI_RREADY_IN,
	// execution state
	output bae_pkg::bae_state_t STATE_OUT,
	output logic               BUSY_OUT
);
	import bae_pkg::*;

	bae_core_t   st_q;        // registered state
	bae_core_t   st_d;        // next state
	bae_dp_if    dp ();       // datapath bundle
	logic [31:0] ins;         // instruction under execution
	logic [3:0]  rd;          // destination index
	logic        pass;        // condition satisfied
	logic        is_br;       // branch class
	logic        is_dp;       // data-processing class
	logic        reg_shift;   // shift amount from a register
	logic        op_arith;    // arithmetic opcode
	logic [31:0] pc_ahead;    // pc as seen by operands
	logic [31:0] br_target;   // branch destination
	logic [31:0] link_val;    // return address

	// condition field against nzcv
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		logic r;
		r = 1'b0;
		unique case (c[3:1])
			3'h0: r = f[`BAE_FL_Z];
			3'h1: r = f[`BAE_FL_C];
			3'h2: r = f[`BAE_FL_N];
			3'h3: r = f[`BAE_FL_V];
			3'h4: r = f[`BAE_FL_C] & ~f[`BAE_FL_Z];
			3'h5: r = f[`BAE_FL_N] == f[`BAE_FL_V];
			3'h6: r = ~f[`BAE_FL_Z] & (f[`BAE_FL_N] == f[`BAE_FL_V]);
			3'h7: r = 1'b1;
		endcase
		// odd codes invert; reserved code thus never runs
		return c[0] ? ~r : r;
	endfunction

	// register operand, pc reads as its prefetch value
	function automatic logic [31:0] gpr_or_pc(input logic [3:0] i,
		input logic [15:0][31:0] g, input logic [31:0] pa);
		return (i == `BAE_PC_IDX) ? pa : g[i];
	endfunction

	// byte-lane merge of a write
	function automatic logic [31:0] merge_bytes(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) m[8*b +: 8] = n[8*b +: 8];
		end
		return m;
	endfunction

	// register readback; bit 32 flags an unmapped address
	function automatic logic [32:0] reg_read(input bae_core_t s, input logic [7:0] a);
		logic [32:0] r;
		r = 33'h0;
		if (a[7:6] == `BAE_GPR_SEL) begin
			r[31:0] = s.gpr[a[5:2]];
		end else begin
			case ({a[7:2], 2'b00})
				`BAE_OFF_INSTR: r[31:0] = s.instr;
				`BAE_OFF_PC:    r[31:0] = s.pc;
				`BAE_OFF_CURRENT_STATUS_REGISTER:  r[31:0] = s.current_status_register;
				`BAE_OFF_SAVED_STATUS_REGISTER:  r[31:0] = s.saved_status_register;
				`BAE_OFF_STAT: begin
					r[`BAE_ST_BUSY]        = s.state[0];
					r[`BAE_ST_PASS]        = s.last_pass;
					r[`BAE_ST_UNSUP]       = s.last_unsup;
					r[`BAE_ST_CYC +: 4]    = s.last_cyc;
				end
				default: r[32] = 1'b1;
			endcase
		end
		return r;
	endfunction

	// decode of the held instruction
	assign ins       = st_q.instr;
	assign rd        = ins[15:12];
	assign pass      = cond_ok(ins[31:28], st_q.current_status_register[`BAE_CURRENT_STATUS_REGISTER_NZCV]);
	assign is_br     = (ins[27:25] == 3'b101);
	assign reg_shift = !ins[25] && ins[4];
	assign is_dp     = (ins[27:26] == 2'b00) && !(reg_shift && ins[7]);
	assign op_arith  = (!ins[24] && ins[23:22] != 2'b00) || (ins[24:22] == 3'b101);
	assign pc_ahead  = st_q.pc + (reg_shift ? `BAE_PC_AHEAD_RS : `BAE_PC_AHEAD);
	assign br_target = st_q.pc + `BAE_PC_AHEAD + {{6{ins[23]}}, ins[23:0], 2'b00};
	assign link_val  = (st_q.pc + `BAE_INSN_BYTES) & `BAE_LINK_MASK;

	// operands to the datapath
	assign dp.instr    = ins;
	assign dp.rn_v     = gpr_or_pc(ins[19:16], st_q.gpr, pc_ahead);
	assign dp.rm_v     = gpr_or_pc(ins[3:0], st_q.gpr, pc_ahead);
	assign dp.rs_v     = gpr_or_pc(ins[11:8], st_q.gpr, pc_ahead);
	assign dp.flags_in = st_q.current_status_register[`BAE_CURRENT_STATUS_REGISTER_NZCV];

	bae_alu u_alu (
		.dp (dp.unit)
	);

	// next state: bus slave, register writes, sequencer
	always_comb begin
		logic [32:0] rb;
		logic [31:0] wv;
		logic [3:0]  cyc;
		rb   = 33'h0;
		wv   = 32'h0;
		cyc  = 4'h0;
		st_d = st_q;
		// read channel
		if (st_q.rvalid && S_AXI_RREADY_IN) begin
			st_d.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_IN && st_q.arready) begin
			rb          = reg_read(st_q, S_AXI_ARADDR_IN);
			st_d.rvalid = 1'b1;
			st_d.rdata  = rb[31:0];
			st_d.rresp  = rb[32] ? `BAE_RESP_SLVERR : `BAE_RESP_OKAY;
		end
		// write channels, taken in either order
		if (st_q.bvalid && S_AXI_BREADY_IN) begin
			st_d.bvalid = 1'b0;
		end
		if (S_AXI_AWVALID_IN && st_q.awready) begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && st_q.wready) begin
			st_d.w_got = 1'b1;
			st_d.wdata = S_AXI_WDATA_IN;
			st_d.wstrb = S_AXI_WSTRB_IN;
		end
		if (st_d.aw_got && st_d.w_got) begin
			rb          = reg_read(st_q, st_d.awaddr);
			wv          = merge_bytes(rb[31:0], st_d.wdata, st_d.wstrb);
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp  = `BAE_RESP_OKAY;
			if (rb[32] || st_q.state != st_idle) begin
				// unmapped, or core busy: refused
				st_d.bresp = `BAE_RESP_SLVERR;
			end else if (st_d.awaddr[7:6] == `BAE_GPR_SEL) begin
				st_d.gpr[st_d.awaddr[5:2]] = wv;
			end else begin
				case ({st_d.awaddr[7:2], 2'b00})
					`BAE_OFF_INSTR: begin
						// writing an instruction launches it
						st_d.instr = wv;
						st_d.state = st_exec;
					end
					`BAE_OFF_PC:   st_d.pc   = wv;
					`BAE_OFF_CURRENT_STATUS_REGISTER: st_d.current_status_register = wv;
					`BAE_OFF_SAVED_STATUS_REGISTER: st_d.saved_status_register = wv;
					default: st_d.bresp = `BAE_RESP_OKAY;
				endcase
			end
		end
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready  = !st_d.w_got && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;
		// instruction sequencer
		unique case (st_q.state)
			st_idle: st_d.cnt = 4'h0;
			st_exec: begin
				cyc     = `BAE_CYC_SKIP;
				st_d.pc = st_q.pc + `BAE_INSN_BYTES;
				if (pass && is_br) begin
					cyc     = `BAE_CYC_BRANCH;
					st_d.pc = br_target;
					if (ins[24]) begin
						st_d.gpr[`BAE_LINK_IDX] = link_val;
					end
				end else if (pass && is_dp) begin
					cyc = reg_shift ? `BAE_CYC_RS : `BAE_CYC_DP;
					if (dp.wr_rd && rd == `BAE_PC_IDX) begin
						cyc     = cyc + `BAE_CYC_PCW;
						st_d.pc = dp.res;
						if (ins[20]) begin
							st_d.current_status_register = st_q.saved_status_register;
						end
					end else begin
						if (dp.wr_rd) begin
							st_d.gpr[rd] = dp.res;
						end
						if (ins[20]) begin
							st_d.current_status_register[`BAE_CURRENT_STATUS_REGISTER_NZCV] = dp.flags_out;
						end
					end
				end
				st_d.last_pass  = pass;
				st_d.last_unsup = pass && !is_br && !is_dp;
				st_d.last_cyc   = cyc;
				st_d.cnt        = cyc - 4'h1;
				st_d.state      = (st_d.cnt != 4'h0) ? st_hold : st_idle;
			end
			st_hold: begin
				st_d.cnt = st_q.cnt - 4'h1;
				if (st_q.cnt == 4'h1) st_d.state = st_idle;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) st_q <= '0;
		else          st_q <= st_d;
	end

	// outputs straight from the state register
	assign S_AXI_AWREADY_OUT = st_q.awready;
	assign S_AXI_WREADY_OUT  = st_q.wready;
	assign S_AXI_BRESP_OUT   = st_q.bresp;
	assign S_AXI_BVALID_OUT  = st_q.bvalid;
	assign S_AXI_ARREADY_OUT = st_q.arready;
	assign S_AXI_RDATA_OUT   = st_q.rdata;
	assign S_AXI_RRESP_OUT   = st_q.rresp;
	assign S_AXI_RVALID_OUT  = st_q.rvalid;
	assign STATE_OUT         = st_q.state;
	assign BUSY_OUT          = st_q.state[0]; // set in exec and hold

	// checks on the execution sequence
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RSTN_IN);

	logic ex_go;  // an instruction is taking effect
	assign ex_go = (st_q.state == st_exec) && pass;

	a_skip_no_effect: assert property ((st_q.state == st_exec) && !pass |=>
		st_q.gpr == $past(st_q.gpr) && st_q.current_status_register == $past(st_q.current_status_register) && st_q.state == st_idle)
		else $error("failed condition changed state or took extra cycles");
	a_branch_target: assert property (ex_go && is_br |=>
		st_q.pc == $past(st_q.pc) + 32'h8 + {{6{$past(ins[23])}}, $past(ins[23:0]), 2'b00})
		else $error("branch target wrong");
	a_link_value: assert property (ex_go && is_br && ins[24] |=>
		st_q.gpr[14] == (($past(st_q.pc) + 32'h4) & 32'hffff_fffc) && st_q.current_status_register == $past(st_q.current_status_register))
		else $error("link register value wrong");
	a_plain_keeps: assert property (ex_go && is_br && !ins[24] |=>
		st_q.gpr[14] == $past(st_q.gpr[14]))
		else $error("plain branch changed link register");
	a_branch_cycles: assert property (ex_go && is_br |=>
		(st_q.state == st_hold)[*2] ##1 (st_q.state == st_idle))
		else $error("branch did not take three cycles");
	a_flags_hold: assert property (ex_go && is_dp && !ins[20] |=>
		st_q.current_status_register == $past(st_q.current_status_register))
		else $error("flags changed without set-flags");
	a_test_no_write: assert property (ex_go && is_dp && ins[24:23] == 2'b10 |=>
		st_q.gpr == $past(st_q.gpr) && st_q.pc == $past(st_q.pc) + 32'h4)
		else $error("test operation wrote a register");
	a_logic_flags: assert property (ex_go && is_dp && ins[20] && !op_arith && rd != 4'hf |=>
		st_q.current_status_register[28] == $past(st_q.current_status_register[28]) && st_q.current_status_register[30] == ($past(dp.res) == 32'h0))
		else $error("logical flags wrong");
	a_arith_flags: assert property (ex_go && is_dp && ins[20] && op_arith && rd != 4'hf |=>
		st_q.current_status_register[31] == $past(dp.res[31]) && st_q.current_status_register[30] == ($past(dp.res) == 32'h0))
		else $error("arithmetic n or z flag wrong");
	a_pc_restore: assert property (ex_go && is_dp && ins[20] && dp.wr_rd && rd == 4'hf |=>
		st_q.current_status_register == $past(st_q.saved_status_register) && st_q.pc == $past(dp.res))
		else $error("pc write did not restore status");

	c_branch_link: cover property (ex_go && is_br && ins[24]);
	c_cond_skip:   cover property ((st_q.state == st_exec) && !pass);
	c_pc_restore:  cover property (ex_go && is_dp && ins[20] && rd == 4'hf);
	c_reg_shift:   cover property (ex_go && is_dp && reg_shift);

endmodule // bae_core

/* File: tb/bae_axi_master.sv */
/*
 * axi4-lite master standing in for software on the register bus.
 * assumes a slave on the same clock; every wait is bounded.
 */
module bae_axi_master (
	// clock
	input  wire logic        clock_in,
	// write channels
	output logic [7:0]       awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic [31:0]      wdata_out,
	output logic [3:0]       wstrb_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic [1:0]  bresp_in,
	input  wire logic        bvalid_in,
	output logic             bready_out,
	// read channels
	output logic [7:0]       araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic [1:0]  rresp_in,
	input  wire logic        rvalid_in,
	output logic             rready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	bit hung; // a wait ran out
	// idle bus at time zero
	initial begin
		awaddr_out = 8'h00;
		awvalid_out = 1'b0;
		wdata_out = 32'h0;
		wstrb_out = 4'hf;
		wvalid_out = 1'b0;
		bready_out = 1'b0;
		araddr_out = 8'h00;
		arvalid_out = 1'b0;
		rready_out = 1'b0;
	end
	// one write; released lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock_in);
		awaddr_out <= a;
		wdata_out <= d;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		do begin
			@(posedge clock_in);
			n++;
			if (awvalid_out && awready_in) begin
				awvalid_out <= 1'b0;
				awaddr_out <= ~a;
			end
			if (wvalid_out && wready_in) begin
				wvalid_out <= 1'b0;
				wdata_out <= ~d;
			end
		end while (!(bvalid_in && bready_out) && n < 40);
		r = bresp_in;
		bready_out <= 1'b0;
		hung |= (n >= 40);
	endtask
	// one read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do begin
			@(posedge clock_in);
			n++;
			if (arvalid_out && arready_in) begin
				arvalid_out <= 1'b0;
				araddr_out <= ~a;
			end
		end while (!(rvalid_in && rready_out) && n < 40);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
		hung |= (n >= 40);
	endtask
endmodule // bae_axi_master

/* File: tb/test_branch_and_alu_execute.sv */
/*
 * bench: random data-processing and branch words through the register bus.
 * assumes the bus master model beside the core.
 */
module test_branch_and_alu_execute;
	timeunit 1ns;
	timeprecision 1ns;
	import bae_pkg::*;
	logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, busy;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, a, b, o3, pc, lk, ins, d;
	logic [3:0]  wstrb, f;
	logic [1:0]  bresp, rresp;
	logic [35:0] e;
	logic        p;
	bae_state_t  state;
	int          failures, checks_done, seed = 40;
	bae_core u_bae_core (
		.CLOCK_IN(clk), .RSTN_IN(rst_n),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .STATE_OUT(state),
		.BUSY_OUT(busy));
	bae_axi_master u_bae_axi_master (
		.clock_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
		.wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
		.bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
		.arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp),
		.rvalid_in(rvalid), .rready_out(rready));
	// 10 mhz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// verdict and end of run
	task automatic stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// compare; a hung bus ends the run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
		if (u_bae_axi_master.hung) begin
			failures++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		logic [1:0] r;
		u_bae_axi_master.wr(ad, v, r);
		check({30'h0, r}, 32'h0);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] v);
		logic [1:0] r;
		u_bae_axi_master.rd(ad, v, r);
		check({30'h0, r}, {30'h0, er});
	endtask
	// launch a word and wait until the core is idle
	task automatic run(input logic [31:0] i);
		int n;
		n = 0;
		wr(8'h00, i);
		// response edge still shows the single exec cycle
		check({30'h0, state}, 32'h1);
		do begin
			@(posedge clk);
			n++;
		end while (busy !== 1'b0 && n < 20);
		if (n >= 20) begin
			failures++;
			stop_test();
		end
	endtask
	// expected flags and result of one data-processing word
	function automatic logic [35:0] dp(input logic [31:0] i, a, m, input logic [3:0] f);
		logic [31:0] b, x, y;
		logic [32:0] s;
		logic [3:0]  op;
		logic        sc, ci, ar;
		op = i[24:21];
		sc = f[1];
		b = m << i[11:7];
		if (!i[25] && i[11:7] != 5'h0) sc = m[6'd32 - i[11:7]];
		if (i[25]) b = ({24'h0, i[7:0]} >> {i[11:8], 1'b0}) |
			({24'h0, i[7:0]} << (6'd32 - {i[11:8], 1'b0}));
		if (i[25] && i[11:8] != 4'h0) sc = b[31];
		x = (op inside {3, 7}) ? ~a : a;
		y = (op inside {2, 6, 10}) ? ~b : b;
		ci = (op inside {2, 3, 10}) ? 1'b1 : ((op inside {5, 6, 7}) ? f[1] : 1'b0);
		ar = op inside {[2:7], 10, 11};
		s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
		case (op)
			4'h0, 4'h8: s = {sc, a & b};
			4'h1, 4'h9: s = {sc, a ^ b};
			4'hc: s = {sc, a | b};
			4'hd: s = {sc, b};
			4'he: s = {sc, a & ~b};
			4'hf: s = {sc, ~b};
			default: ;
		endcase
		return {s[31], s[31:0] == 32'h0, s[32],
			ar ? (x[31] == y[31] && s[31] != x[31]) : f[0], s[31:0]};
	endfunction
	// main sequence
	initial begin
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h04, 2'b00, d);
		check(d, 32'h0);
		rd(8'h20, 2'b10, d);
		for (int k = 0; k < 40; k++) begin
			a = $random(seed);
			b = $random(seed);
			o3 = $random(seed);
			f = 4'($random(seed));
			ins = $random(seed);
			if (k[3:0] == 4'h4) a = 32'h7fff_ffff;
			ins[31:28] = k < 32 ? 4'he : (k[0] ? 4'h0 : 4'hf);
			ins[27:26] = 2'b00;
			ins[24:21] = k[3:0];
			ins[20] = ins[20] | (k[3:2] == 2'b10);
			ins[19:12] = 8'h13;
			if (!ins[25]) ins[6:0] = 7'h02;
			p = k < 32 || (k[0] && f[2]);
			wr(8'h44, a);
			wr(8'h48, b);
			wr(8'h4c, o3);
			wr(8'h08, {f, 28'h0});
			run(ins);
			e = dp(ins, a, b, f);
			rd(8'h4c, 2'b00, d);
			check(d, (p && k[3:2] != 2'b10) ? e[31:0] : o3);
			rd(8'h08, 2'b00, d);
			check(d, {(p && ins[20]) ? e[35:32] : f, 28'h0});
			rd(8'h10, 2'b00, d);
			check(d[11:0], {4'h1, 6'h0, p, 1'b0});
		end
		for (int k = 0; k < 8; k++) begin
			pc = $random(seed);
			lk = $random(seed);
			ins = {4'he, 3'b101, k[0], 24'h0} | ($random(seed) & 32'h00ff_ffff);
			if (k == 0) ins[23:0] = 24'h80_0000;
			wr(8'h04, pc);
			wr(8'h78, lk);
			run(ins);
			rd(8'h04, 2'b00, d);
			check(d, pc + 32'h8 + {{6{ins[23]}}, ins[23:0], 2'b00});
			rd(8'h78, 2'b00, d);
			check(d, k[0] ? ((pc + 32'h4) & 32'hffff_fffc) : lk);
			rd(8'h10, 2'b00, d);
			check(d[11:8], 4'h3);
		end
		// corner cases: right shift by 32, register-amount arith shift, pc write
		wr(8'h48, 32'h8000_0018);
		wr(8'h50, 32'h0000_0028);
		wr(8'h0c, 32'h5000_0000);
		wr(8'h08, 32'h1000_0000);
		run(32'he1b0_3022);
		rd(8'h4c, 2'b00, d);
		check(d, 32'h0);
		rd(8'h08, 2'b00, d);
		check(d, 32'h7000_0000);
		run(32'he1b0_3452);
		rd(8'h4c, 2'b00, d);
		check(d, 32'hffff_ffff);
		rd(8'h08, 2'b00, d);
		check(d, 32'hb000_0000);
		rd(8'h10, 2'b00, d);
		check(d[11:8], 4'h2);
		run(32'he3b0_f040);
		rd(8'h04, 2'b00, d);
		check(d, 32'h0000_0040);
		rd(8'h08, 2'b00, d);
		check(d, 32'h5000_0000);
		rd(8'h10, 2'b00, d);
		check(d[11:8], 4'h3);
		stop_test();
	end
endmodule // test_branch_and_alu_execute
